// ---- verilog/dps_pkg.sv ----
// Package: shared constants and types for the power-state command link
package dps_pkg;
  localparam int dps_bank_w = 2;
  localparam int dps_addr_w = 14;
  localparam int dps_col_w = 10;
  localparam int dps_ap_bit = 10;
  localparam int dps_nbanks = 4;
  localparam int dps_data_w = 8;
  localparam int dps_mem_words = 64;
  localparam int dps_mem_aw = 6;
  localparam int dps_clk_ns = 50;
  localparam int dps_cke_hold_clk = 3;
  localparam int dps_xsrd_clk = 200;
  localparam int dps_xsnr_ns = 200;
  localparam int dps_xsnr_clk = (dps_xsnr_ns + dps_clk_ns - 1) / dps_clk_ns;
  localparam int dps_mrd_clk = 2;
  localparam int dps_burst_len = 4;
  localparam int dps_cnt_w = 8;
  localparam logic [2:0] dps_al_max = 3'h5;
  localparam logic [1:0] dps_mr_ext1 = 2'h1;
  localparam logic [dps_addr_w-1:0] dps_odt_en_mask = 14'h0044;

  // Command encoding: {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    dps_cmd_mrs = 4'h0,
    dps_cmd_ref = 4'h1,
    dps_cmd_pre = 4'h2,
    dps_cmd_act = 4'h3,
    dps_cmd_wr = 4'h4,
    dps_cmd_rd = 4'h5,
    dps_cmd_nop = 4'h7,
    dps_cmd_desel = 4'h8
  } dps_cmd_type;

  typedef enum logic [2:0] {
    dps_st_idle = 3'h0,
    dps_st_active = 3'h1,
    dps_st_act_pd = 3'h3,
    dps_st_pre_pd = 3'h2,
    dps_st_self_ref = 3'h6,
    dps_st_illegal = 3'h7
  } dps_state_type;

  function automatic logic dps_is_quiet(input logic [3:0] c);
    return c[3] || (c[2:0] == 3'h7);
  endfunction
endpackage

// ---- verilog/dps_link_if.sv ----
// Interface: command, clock-enable, termination and write data pins
`timescale 1ns/100ps
interface dps_link_if;
  import dps_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [dps_bank_w-1:0] ba;
  logic [dps_addr_w-1:0] addr;
  logic odt;
  logic dm;
  logic [dps_data_w-1:0] dq_wr;
  logic dq_wr_valid;
  logic [dps_data_w-1:0] dq_rd;
  logic dq_rd_valid;
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dq_wr, dq_wr_valid,
    output dq_rd, dq_rd_valid);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dq_wr, dq_wr_valid,
    input dq_rd, dq_rd_valid);
endinterface

// ---- verilog/dps_mem_end.sv ----
// Memory end: clock-enable state machine, command decode, banks and masked writes
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module dps_mem_end
  import dps_pkg::*;
(
  input wire logic ref_clk, // Device clock
  input wire logic rstn, // Async reset, active low
  dps_link_if.mem link, // Pins from controller
  input wire logic [2:0] al_cfg, // Additive latency in clocks
  output dps_pkg::dps_state_type state, // Present power state
  output logic dll_on, // Delay-locked loop enabled
  output logic odt_active, // Termination applied
  output logic illegal_seen, // Sticky illegal sequence flag
  output logic [dps_addr_w-1:0] mode_reg_0, // Mode register 0
  output logic [dps_addr_w-1:0] mode_reg_1 // Extended mode register 1
);
  import dps_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  dps_state_type st_q, st_d;
  logic cke_prev_q;
  logic illegal_q;
  logic [dps_addr_w-1:0] mr_q [dps_nbanks];
  logic [dps_nbanks-1:0] open_q;
  logic [dps_addr_w-1:0] row_q [dps_nbanks];
  logic [dps_cnt_w-1:0] busy_q;
  logic [dps_cnt_w-1:0] xs_q;
  logic [dps_data_w-1:0] mem_q [dps_mem_words];
  logic [dps_data_w-1:0] rd_q;
  logic rd_v_q;
  // Read burst walker: one word per clock, so a burst never stalls the array
  logic [dps_bank_w+dps_col_w-1:0] rd_ptr_q;
  logic [2:0] rd_left_q;
  // Posted read/write pipeline: {valid, is_write, ap, bank, column}
  localparam int pw = 3 + dps_bank_w + dps_col_w;
  logic [pw-1:0] post_q [8];
  logic [dps_bank_w+dps_col_w-1:0] wr_ptr_q;
  logic [2:0] wr_left_q;
  logic wr_ap_q;
  logic [dps_bank_w-1:0] ap_bank_q;
  logic ap_pend_q;

  // command sampled at the rising edge from pin levels
  wire [3:0] cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  wire quiet = dps_is_quiet(cmd);
  wire cke_fall = cke_prev_q && !link.cke;
  wire cke_rise = !cke_prev_q && link.cke;
  wire run = cke_prev_q && link.cke;
  wire any_open = |open_q;
  wire busy = busy_q != '0;
  wire [dps_bank_w-1:0] bk = link.ba;
  wire is_cmd = run && !link.cs_n;
  wire [pw-1:0] post_new = {is_cmd && (cmd == dps_cmd_rd || cmd == dps_cmd_wr), cmd == dps_cmd_wr,
    link.addr[dps_ap_bit], bk, link.addr[dps_col_w-1:0]};
  wire [pw-1:0] post_out = post_q[al_cfg];
  wire post_fire = post_out[pw-1];
  wire [dps_mem_aw-1:0] wr_idx = dps_mem_aw'(wr_ptr_q);

  // Next power state with legality of each clock-enable transition
  logic bad;
  always_comb
  begin
    st_d = st_q;
    bad = 1'b0;
    unique case (st_q)
      dps_st_idle, dps_st_active:
      begin
        if (cke_fall)
        begin
          if (cmd == dps_cmd_ref && !any_open && !busy)
            st_d = dps_st_self_ref;
          else if (quiet && !busy)
            st_d = any_open ? dps_st_act_pd : dps_st_pre_pd;
          else
            bad = 1'b1;
        end
        else if (link.cke)
          st_d = any_open ? dps_st_active : dps_st_idle;
      end
      dps_st_act_pd, dps_st_pre_pd:
      begin
        if (cke_rise)
        begin
          bad = !quiet;
          st_d = (st_q == dps_st_act_pd) ? dps_st_active : dps_st_idle;
        end
      end
      dps_st_self_ref:
      begin
        if (cke_rise)
        begin
          bad = !quiet;
          st_d = dps_st_idle;
        end
      end
      default:
        st_d = dps_st_idle;
    endcase
    if (xs_q != '0 && run && ((xs_q > dps_cnt_w'(dps_xsrd_clk - dps_xsnr_clk) && !quiet) ||
        cmd == dps_cmd_rd))
      bad = 1'b1;
    if (is_cmd && cmd == dps_cmd_mrs && any_open)
      bad = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= dps_st_idle;
      cke_prev_q <= 1'b0;
      illegal_q <= 1'b0;
      xs_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cke_prev_q <= link.cke;
      illegal_q <= illegal_q | bad;
      if (st_q == dps_st_self_ref && cke_rise)
        xs_q <= dps_cnt_w'(dps_xsrd_clk);
      else if (xs_q != '0)
        xs_q <= xs_q - 1'b1;
    end
  end

  // Bank, mode register and busy tracking
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      open_q <= '0;
      busy_q <= '0;
      ap_pend_q <= 1'b0;
      ap_bank_q <= '0;
      for (int i = 0; i < dps_nbanks; i++)
      begin
        mr_q[i] <= '0;
        row_q[i] <= '0;
      end
    end
    else
    begin
      if (busy)
        busy_q <= busy_q - 1'b1;
      if (ap_pend_q && busy_q == dps_cnt_w'(1))
      begin
        open_q[ap_bank_q] <= 1'b0;
        ap_pend_q <= 1'b0;
      end
      if (is_cmd)
      begin
        unique case (cmd)
          dps_cmd_mrs:
          begin
            mr_q[bk] <= link.addr;
            busy_q <= dps_cnt_w'(dps_mrd_clk);
          end
          dps_cmd_act:
          begin
            if (!open_q[bk])
            begin
              open_q[bk] <= 1'b1;
              row_q[bk] <= link.addr;
            end
          end
          dps_cmd_pre:
          begin
            if (link.addr[dps_ap_bit])
              open_q <= '0;
            else
              open_q[bk] <= 1'b0;
          end
          dps_cmd_rd, dps_cmd_wr:
            busy_q <= dps_cnt_w'(al_cfg) + dps_cnt_w'(dps_burst_len) + dps_cnt_w'(1);
          default:
            ;
        endcase
      end
      if (post_fire && post_out[pw-3]) // close after the burst
      begin
        ap_pend_q <= 1'b1;
        ap_bank_q <= post_out[dps_col_w +: dps_bank_w];
        busy_q <= dps_cnt_w'(dps_burst_len);
      end
    end
  end

  // posted commands delayed by the additive latency
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 8; i++)
        post_q[i] <= '0;
    end
    else
    begin
      post_q[0] <= post_new;
      for (int i = 1; i < 8; i++)
        post_q[i] <= post_q[i-1];
    end
  end

  // Burst data path with write mask
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_q <= '0;
      wr_left_q <= '0;
      wr_ap_q <= 1'b0;
      rd_q <= '0;
      rd_v_q <= 1'b0;
      rd_ptr_q <= '0;
      rd_left_q <= '0;
    end
    else
    begin
      rd_v_q <= 1'b0;
      if (rd_left_q != '0) // one burst word per clock
      begin
        rd_q <= mem_q[dps_mem_aw'(rd_ptr_q)];
        rd_v_q <= 1'b1;
        rd_ptr_q <= rd_ptr_q + 1'b1;
        rd_left_q <= rd_left_q - 1'b1;
      end
      if (post_fire && post_out[pw-2])
      begin
        wr_ptr_q <= post_out[dps_bank_w+dps_col_w-1:0];
        wr_left_q <= 3'(dps_burst_len);
        wr_ap_q <= post_out[pw-3];
      end
      else if (post_fire)
      begin
        rd_ptr_q <= post_out[dps_bank_w+dps_col_w-1:0];
        rd_left_q <= 3'(dps_burst_len);
      end
      else if (wr_left_q != '0 && link.dq_wr_valid)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
        wr_left_q <= wr_left_q - 1'b1;
      end
    end
  end

  // Small array; DM high leaves the byte untouched
  always_ff @(posedge ref_clk)
  begin
    if (wr_left_q != '0 && link.dq_wr_valid && !link.dm)
      mem_q[wr_idx] <= link.dq_wr;
  end

  assign link.dq_rd = rd_q;
  assign link.dq_rd_valid = rd_v_q;
  assign state = st_q;
  assign dll_on = st_q != dps_st_self_ref;
  // ODT pin has no say in state; termination dropped in self refresh
  assign odt_active = link.odt && (st_q != dps_st_self_ref) && ((mr_q[dps_mr_ext1] & dps_odt_en_mask) != '0);
  assign illegal_seen = illegal_q;
  assign mode_reg_0 = mr_q[0];
  assign mode_reg_1 = mr_q[dps_mr_ext1];
endmodule // dps_mem_end

// ---- verilog/dps_ctl_end.sv ----
// Controller end: drives commands and clock enable with legal timing; open banks before self refresh or mode set are left to the caller
`timescale 1ns/100ps
module dps_ctl_end
  import dps_pkg::*;
(
  input wire logic ref_clk, // Controller clock
  input wire logic rstn, // Async reset, active low
  dps_link_if.ctl link, // Pins to memory
  input wire logic req_valid, // User command request
  output logic req_ready, // Request taken this cycle
  input wire dps_pkg::dps_cmd_type req_cmd, // Command to issue
  input wire logic [dps_bank_w-1:0] req_ba, // Bank address
  input wire logic [dps_addr_w-1:0] req_addr, // Row, column or opcode
  input wire logic pd_req, // Request power-down
  input wire logic sr_req, // Request self refresh
  input wire logic wake_req, // Request low-power exit
  input wire logic ocd_cal, // Driver calibration active
  input wire logic odt_level, // Termination level wanted
  input wire logic [dps_data_w-1:0] wdata, // Write data beat
  input wire logic wmask, // Byte mask for beat
  input wire logic wvalid, // Beat valid
  output logic [dps_data_w-1:0] rdata, // Read data
  output logic rvalid, // Read data valid
  output logic low_power // Memory in low-power state
);
  import dps_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  logic cke_q;
  logic [3:0] cmd_q;
  logic [dps_bank_w-1:0] ba_q;
  logic [dps_addr_w-1:0] addr_q;
  logic [dps_cnt_w-1:0] hold_q;
  logic [dps_cnt_w-1:0] xs_q;
  logic [dps_cnt_w-1:0] busy_q;
  logic sr_q;
  logic [dps_data_w-1:0] wd_q;
  logic dm_q;
  logic wv_q;
  logic [dps_data_w-1:0] rd_q;
  logic rv_q;

  wire hold_ok = hold_q == '0;
  wire can_sleep = cke_q && hold_ok && busy_q == '0 && !ocd_cal;
  wire go_sr = can_sleep && sr_req;
  wire go_pd = can_sleep && pd_req && !sr_req; // caller bounds the stay
  wire go_wake = !cke_q && hold_ok && (wake_req || ocd_cal);
  wire in_xsnr = xs_q > dps_cnt_w'(dps_xsrd_clk - dps_xsnr_clk);
  wire rd_block = xs_q != '0 && req_cmd == dps_cmd_rd;
  wire issue = req_valid && cke_q && !go_sr && !go_pd && !in_xsnr && !rd_block;
  assign req_ready = issue;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cke_q <= 1'b0;
      cmd_q <= dps_cmd_desel;
      ba_q <= '0;
      addr_q <= '0;
      hold_q <= dps_cnt_w'(dps_cke_hold_clk);
      xs_q <= '0;
      busy_q <= '0;
      sr_q <= 1'b0;
    end
    else
    begin
      cmd_q <= dps_cmd_nop; // quiet unless a legal command
      if (hold_q != '0)
        hold_q <= hold_q - 1'b1;
      if (xs_q != '0)
        xs_q <= xs_q - 1'b1;
      if (busy_q != '0)
        busy_q <= busy_q - 1'b1;
      if (go_sr)
      begin
        cke_q <= 1'b0;
        cmd_q <= dps_cmd_ref;
        sr_q <= 1'b1;
        hold_q <= dps_cnt_w'(dps_cke_hold_clk);
      end
      else if (go_pd || (!cke_q && !go_wake) || (cke_q && !hold_ok && !cke_q))
      begin
        cke_q <= cke_q && !go_pd;
        if (go_pd)
          hold_q <= dps_cnt_w'(dps_cke_hold_clk);
      end
      else if (go_wake)
      begin
        cke_q <= 1'b1;
        hold_q <= dps_cnt_w'(dps_cke_hold_clk);
        sr_q <= 1'b0;
        if (sr_q)
          xs_q <= dps_cnt_w'(dps_xsrd_clk);
      end
      else if (issue)
      begin
        cmd_q <= req_cmd;
        ba_q <= req_ba;
        addr_q <= req_addr;
        if (req_cmd != dps_cmd_nop && req_cmd != dps_cmd_desel && req_cmd != dps_cmd_act)
          busy_q <= dps_cnt_w'(dps_burst_len + 2 * int'(dps_al_max) + 1);
      end
    end
  end

  // Write beats and read capture registered on the controller side
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wd_q <= '0;
      dm_q <= 1'b1;
      wv_q <= 1'b0;
      rd_q <= '0;
      rv_q <= 1'b0;
    end
    else
    begin
      wd_q <= wdata;
      dm_q <= wmask;
      wv_q <= wvalid;
      rv_q <= link.dq_rd_valid;
      if (link.dq_rd_valid)
        rd_q <= link.dq_rd;
    end
  end

  assign link.cke = cke_q;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_q;
  assign link.ba = ba_q;
  assign link.addr = addr_q;
  assign link.odt = odt_level; // always a defined level
  assign link.dm = dm_q;
  assign link.dq_wr = wd_q;
  assign link.dq_wr_valid = wv_q;
  assign rdata = rd_q;
  assign rvalid = rv_q;
  assign low_power = !cke_q;
endmodule // dps_ctl_end

// ---- tb/dps_chk.sv ----
// Checker: command and clock-enable rules watched on the link pins
`timescale 1ns/100ps
module dps_chk
  import dps_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic cke, // Clock enable
  input wire logic cs_n, // Chip select
  input wire logic ras_n, // Row strobe
  input wire logic cas_n, // Column strobe
  input wire logic we_n, // Write enable
  input wire logic [dps_bank_w-1:0] ba, // Bank
  input wire logic [dps_addr_w-1:0] addr // Row, column or opcode
);
  logic cke_q;
  logic sr_q;
  logic [3:0] open_q;
  logic [7:0] xs_q;
  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire logic quiet = cs_n | (ras_n & cas_n & we_n);
  wire logic live = cke & cke_q & ~cs_n;
  wire logic [3:0] bsel = 4'h1 << ba;
  wire logic act = live & (cmd[2:0] == 3'h3);
  wire logic pre = live & (cmd[2:0] == 3'h2);
  wire logic mrs = live & (cmd[2:0] == 3'h0);
  wire logic rw = live & (cmd[2:1] == 2'h2);
  wire logic is_rd = live & (cmd[2:0] == 3'h5);
  wire logic sre = cke_q & ~cke & ~cs_n & (cmd[2:0] == 3'h1);
  wire logic srx = sr_q & cke;
  // Auto-precharge is counted as closing at once; this only makes the idle and activate checks looser
  wire logic [3:0] clr = (pre & addr[dps_ap_bit]) ? 4'hf : ((pre | (rw & addr[dps_ap_bit])) ? bsel : 4'h0);
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cke_q <= 1'h0;
      sr_q <= 1'h0;
      open_q <= 4'h0;
      xs_q <= 8'hff;
    end
    else
    begin
      cke_q <= cke;
      sr_q <= sre | (sr_q & ~cke);
      open_q <= (open_q & ~clr) | (act ? bsel : 4'h0);
      xs_q <= srx ? 8'h01 : xs_q + {7'h0, xs_q != 8'hff};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_xsnr;
    quiet [*4];
  endsequence
  a_cke_hold: assert property ($changed(cke) |=> $stable(cke) [*2]) else $error("cke toggled too soon");
  a_wake_quiet: assert property ((cke & ~cke_q) |-> quiet) else $error("command on cke rise");
  a_sleep_quiet: assert property ((~cke & cke_q) |-> quiet | sre) else $error("command on cke fall");
  a_sr_idle: assert property (sre |-> open_q == 4'h0) else $error("self refresh with open bank");
  a_xsnr_quiet: assert property (srx |-> s_xsnr) else $error("command during exit delay");
  a_xsrd_read: assert property (is_rd |-> xs_q >= 8'hc8) else $error("read too soon after exit");
  a_busy_awake: assert property ((rw | mrs | pre) |=> cke [*8]) else $error("sleep during operation");
  a_mrs_idle: assert property (mrs |-> open_q == 4'h0) else $error("mode set with open bank");
  a_cmd_legal: assert property (live |-> cmd[2:0] != 3'h6) else $error("reserved command");
  a_act_closed: assert property (act |-> (open_q & bsel) == 4'h0) else $error("activate on open bank");
endmodule // dps_chk

// ---- tb/tb.sv ----
// Testbench: both link ends joined and driven through the user request port
`timescale 1ns/100ps
module tb;
  import dps_pkg::*;
  logic ref_clk, rstn, req_valid, req_ready, pd_req, sr_req, wake_req, ocd_cal, odt_level;
  logic wmask, wvalid, rvalid, low_power, dll_on, odt_active, illegal_seen;
  dps_cmd_type req_cmd;
  dps_state_type state;
  logic [dps_bank_w-1:0] req_ba;
  logic [dps_addr_w-1:0] req_addr, mr1;
  logic [dps_data_w-1:0] wdata, rdata;
  logic [dps_data_w-1:0] img [4];
  logic [2:0] al_cfg;
  int err_count, n_checks;
  realtime t0;
  dps_link_if lk();
  dps_ctl_end i_dps_ctl_end(.ref_clk(ref_clk), .rstn(rstn), .link(lk), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr), .pd_req(pd_req),
    .sr_req(sr_req), .wake_req(wake_req), .ocd_cal(ocd_cal), .odt_level(odt_level), .wdata(wdata),
    .wmask(wmask), .wvalid(wvalid), .rdata(rdata), .rvalid(rvalid), .low_power(low_power));
  dps_mem_end i_dps_mem_end(.ref_clk(ref_clk), .rstn(rstn), .link(lk), .al_cfg(al_cfg), .state(state),
    .dll_on(dll_on), .odt_active(odt_active), .illegal_seen(illegal_seen), .mode_reg_0(), .mode_reg_1(mr1));
  dps_chk i_dps_chk(.ref_clk(ref_clk), .rstn(rstn), .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n),
    .cas_n(lk.cas_n), .we_n(lk.we_n), .ba(lk.ba), .addr(lk.addr));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Ready is combinational, so it is judged mid-cycle ahead of the edge that takes the request
  task automatic issue(input dps_cmd_type c, input logic [1:0] b, input logic [13:0] a);
    int n;
    n = 0;
    req_cmd = c;
    req_ba = b;
    req_addr = a;
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 400)
    begin
      @(negedge ref_clk);
      #1;
      n++;
    end
    chk("req_ready", 1'b1, req_ready);
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  task automatic wr(input logic [1:0] b, input logic [3:0] m, input logic [31:0] d);
    issue(dps_cmd_wr, b, 14'h0000);
    repeat (al_cfg + 1) @(negedge ref_clk);
    for (int i = 0; i < 4; i++)
    begin
      wdata = d[8*i+:8];
      wmask = m[i];
      wvalid = 1'b1;
      if (!m[i])
        img[i] = d[8*i+:8];
      @(negedge ref_clk);
    end
    wvalid = 1'b0;
  endtask
  task automatic rd(input logic [1:0] b, input logic ap);
    int n, k, f;
    n = 0;
    k = 0;
    f = 0;
    issue(dps_cmd_rd, b, {3'h0, ap, 10'h000});
    while (k < 4 && n < 60)
    begin
      @(negedge ref_clk);
      n++;
      if (lk.dq_rd_valid === 1'b1 && f == 0)
        f = n;
      if (rvalid === 1'b1)
      begin
        chk("rdata", img[k], rdata);
        k++;
      end
    end
    chk("read latency", al_cfg + 3, f);
    chk("read beats", 4, k);
  endtask
  task automatic sleep(input logic s, input dps_state_type e);
    pd_req = !s;
    sr_req = s;
    for (int n = 0; n < 60 && lk.cke !== 1'b0; n++)
      @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    chk("state", e, state);
    chk("low_power", 1'b1, low_power);
  endtask
  task automatic wake();
    pd_req = 1'b0;
    sr_req = 1'b0;
    wake_req = 1'b1;
    issue(dps_cmd_nop, 2'h0, 14'h0000);
    wake_req = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Whole run is under 500 cycles; this allows several times that
  initial
  begin
    #400000;
    err_count++;
    conclude();
  end
  initial
  begin
    rstn = 1'b0;
    {req_valid, pd_req, sr_req, wake_req, ocd_cal, odt_level, wmask, wvalid} = 8'h00;
    req_cmd = dps_cmd_nop;
    req_ba = 2'h0;
    req_addr = 14'h0000;
    wdata = 8'h00;
    al_cfg = 3'h0;
    err_count = 0;
    n_checks = 0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    wake();
    chk("cke", 1'b1, lk.cke);
    issue(dps_cmd_mrs, dps_mr_ext1, 14'h0004);
    repeat (4) @(negedge ref_clk);
    chk("mode_reg_1", 14'h0004, mr1);
    odt_level = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("odt_active", 1'b1, odt_active);
    for (int i = 0; i < 2; i++)
    begin
      al_cfg = i ? 3'h5 : 3'h0;
      issue(dps_cmd_act, 2'h1, 14'h0005);
      repeat (2) @(negedge ref_clk);
      chk("state", dps_st_active, state);
      wr(2'h1, 4'h0, 32'h44332211 + i);
      wr(2'h1, 4'h2, 32'h88776655);
      repeat (6) @(negedge ref_clk);
      rd(2'h1, i[0]);
      repeat (20) @(negedge ref_clk);
      chk("state", i ? dps_st_idle : dps_st_active, state);
      if (i == 0)
        issue(dps_cmd_pre, 2'h1, 14'h0000);
    end
    sleep(1'b0, dps_st_pre_pd);
    wake();
    issue(dps_cmd_act, 2'h2, 14'h0001);
    issue(dps_cmd_desel, 2'h0, 14'h0000);
    repeat (2) @(negedge ref_clk);
    chk("state", dps_st_active, state);
    sleep(1'b0, dps_st_act_pd);
    wake();
    issue(dps_cmd_pre, 2'h2, 14'h0400);
    issue(dps_cmd_nop, 2'h0, 14'h0000);
    repeat (2) @(negedge ref_clk);
    chk("state", dps_st_idle, state);
    repeat (16) @(negedge ref_clk);
    sleep(1'b1, dps_st_self_ref);
    chk("dll_on", 1'b0, dll_on);
    chk("odt_active", 1'b0, odt_active);
    sr_req = 1'b0;
    wake_req = 1'b1;
    for (int n = 0; n < 60 && lk.cke !== 1'b1; n++)
      @(negedge ref_clk);
    t0 = $realtime;
    issue(dps_cmd_act, 2'h1, 14'h0005);
    wake_req = 1'b0;
    rd(2'h1, 1'b1);
    chk("read after exit", 1'b1, ($realtime - t0) >= 200 * dps_clk_ns);
    chk("dll_on", 1'b1, dll_on);
    ocd_cal = 1'b1;
    pd_req = 1'b1;
    repeat (20) @(negedge ref_clk);
    chk("cke", 1'b1, lk.cke);
    ocd_cal = 1'b0;
    pd_req = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("illegal_seen", 1'b0, illegal_seen);
    conclude();
  end
endmodule // tb
